/* File: design/slpc_regs.svh */
// Register offsets, field positions, reset values and timing counts of the port controller.
`ifndef SLPC_REGS_SVH
`define SLPC_REGS_SVH
`define SLPC_OFS_CTRL 8'h00
`define SLPC_OFS_STATUS 8'h04
`define SLPC_OFS_PTRS 8'h08
`define SLPC_OFS_FLAGS 8'h0C
`define SLPC_OFS_REQ 8'h10
`define SLPC_OFS_CHAR 8'h14
`define SLPC_CTRL_ENABLE 0
`define SLPC_CTRL_DISABLE 1
`define SLPC_CTRL_RETRY_RESET 2
`define SLPC_CTRL_CLR_ERR 3
`define SLPC_READY_FLAGS 4'hA
`define SLPC_DIS_MIN_CHARS 16'h00C8
`define SLPC_NBUF 8
`define SLPC_PTR_W 3
`define SLPC_RX_BYTES 135
`define SLPC_SEQ_INIT 2'h0
`endif

/* File: design/slpc_pkg.sv */
// Types of the serial link port controller.
package slpc_pkg;
  typedef enum logic [3:0] {
    SLPC_DISABLED = 4'h1,
    SLPC_ENABLED = 4'h2,
    SLPC_READY = 4'h4,
    SLPC_CHECK = 4'h8
  } slpc_state_type;
  typedef enum logic [3:0] {
    SLPC_CH_DIS = 4'h0,
    SLPC_CH_FLAG = 4'h1,
    SLPC_CH_ACK = 4'h2,
    SLPC_CH_RR = 4'h3,
    SLPC_CH_ABORT = 4'h4,
    SLPC_CH_SAT = 4'h5,
    SLPC_CH_SATP = 4'h6,
    SLPC_CH_USER = 4'h7,
    SLPC_CH_FWD_RESET = 4'h8,
    SLPC_CH_CTRL_FRAME = 4'h9,
    SLPC_CH_OWN_FRAME = 4'hA,
    SLPC_CH_FWD_FRAME = 4'hB,
    SLPC_CH_CUR_FRAME = 4'hC
  } slpc_char_type;
endpackage

/* File: design/slpc_port.sv */
// Port state machine and transmit priority arbiter of one serial link port.
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`include "slpc_regs.svh"
module slpc_port (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic resetn_i,
  // AXI4-Lite write channels.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Character period strobe and receiver events.
  input wire logic char_tick_i,
  input wire logic rx_sync_i,
  input wire logic rx_flag_i,
  input wire logic rx_ack_pair_i,
  input wire logic rx_rr_pair_i,
  input wire logic rx_link_reset_i,
  input wire logic rx_reset_frame_i,
  input wire logic error_i,
  input wire logic line_fault_i,
  input wire logic recovery_i,
  // Frame sources and their state.
  input wire logic sat_pending_i,
  input wire logic satp_pending_i,
  input wire logic sat_token_i,
  input wire logic user_pending_i,
  input wire logic cur_frame_i,
  input wire logic cur_frame_end_i,
  input wire logic cur_frame_abort_i,
  input wire logic fwd_reset_i,
  input wire logic fwd_frame_i,
  // Transmitter output and pointer status.
  output logic [3:0] tx_char_o,
  output logic [3:0] port_state_o,
  output logic [2:0] tx_ptr_o,
  output logic [2:0] retry_ptr_o,
  output logic rx_accept_o
);
  slpc_pkg::slpc_state_type state, next_state;
  slpc_pkg::slpc_char_type next_char;
  logic [3:0] tx_char;
  logic [3:0] flag_cnt;
  logic [15:0] dis_cnt;
  logic [1:0] tx_seq, rx_seq;
  logic wait_rr, rr_pend, wait_ack, ack_pend, link_reset_flag, err_latch;
  logic [2:0] tx_ptr, retry_ptr;
  logic [2:0] pair_half;
  logic ack_req, rr_req, ctrl_req, own_req, user_req;
  logic cmd_enable, cmd_disable;
  logic [7:0] rx_len;
  logic [3:0] unacked;
  logic aw_hold, w_hold, s_axi_bvalid_r, s_axi_rvalid_r;
  logic [7:0] aw_addr;
  logic [31:0] w_data, rdata;
  logic w_strb0;

  // Write channel capture; address and data are taken in either order.
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb0 <= 1'b0;
      s_axi_bvalid_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && !aw_hold && !s_axi_bvalid_r) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold && !s_axi_bvalid_r) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb0 <= s_axi_wstrb[0];
      end
      if (aw_hold && w_hold) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid_r <= 1'b1;
      end else if (s_axi_bvalid_r && s_axi_bready) begin
        s_axi_bvalid_r <= 1'b0;
      end
    end
  end
  assign s_axi_awready = 1'b1 & !aw_hold & !s_axi_bvalid_r;
  assign s_axi_wready = !w_hold & !s_axi_bvalid_r;
  assign s_axi_bvalid = s_axi_bvalid_r;
  assign s_axi_bresp = 2'h0;

  // Command decode; the captured byte lane zero strobe gates every control bit.
  // The strobe is held with the data, because the master may drop it once the data is taken.
  logic wr_go;
  assign wr_go = aw_hold && w_hold && w_strb0;
  assign cmd_enable = wr_go && aw_addr == `SLPC_OFS_CTRL && w_data[`SLPC_CTRL_ENABLE];
  assign cmd_disable = wr_go && aw_addr == `SLPC_OFS_CTRL && w_data[`SLPC_CTRL_DISABLE];

  // Software origination requests for ACK, RR, control and own frames.
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ack_req <= 1'b0;
      rr_req <= 1'b0;
      ctrl_req <= 1'b0;
      own_req <= 1'b0;
      user_req <= 1'b0;
    end else begin
      if (wr_go && aw_addr == `SLPC_OFS_REQ) begin
        ack_req <= ack_req | w_data[0];
        rr_req <= rr_req | w_data[1];
        ctrl_req <= ctrl_req | w_data[2];
        own_req <= own_req | w_data[3];
        user_req <= user_req | w_data[4];
      end
      if (char_tick_i) begin
        if (next_char == slpc_pkg::SLPC_CH_ACK && pair_half == 3'h0) ack_req <= 1'b0;
        if (next_char == slpc_pkg::SLPC_CH_RR && pair_half == 3'h0) rr_req <= 1'b0;
        if (next_char == slpc_pkg::SLPC_CH_CTRL_FRAME) ctrl_req <= 1'b0;
        if (next_char == slpc_pkg::SLPC_CH_OWN_FRAME) own_req <= 1'b0;
        if (next_char == slpc_pkg::SLPC_CH_USER) user_req <= 1'b0;
      end
    end
  end

  // Read channel; unmapped offsets read zero with an OKAY answer.
  always_comb begin
    rdata = 32'h00000000;
    unique case (s_axi_araddr)
      `SLPC_OFS_STATUS: rdata = {24'h000000, err_latch, link_reset_flag, 2'h0, port_state_o};
      `SLPC_OFS_PTRS: rdata = {20'h00000, unacked, 1'b0, retry_ptr, 1'b0, tx_ptr};
      `SLPC_OFS_FLAGS: rdata = {24'h000000, tx_seq, rx_seq, wait_rr, rr_pend, wait_ack, ack_pend};
      `SLPC_OFS_REQ: rdata = {27'h0000000, user_req, own_req, ctrl_req, rr_req, ack_req};
      `SLPC_OFS_CHAR: rdata = {24'h000000, rx_len};
      default: rdata = 32'h00000000;
    endcase
  end
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      s_axi_rvalid_r <= 1'b0;
      s_axi_rdata <= 32'h00000000;
    end else if (s_axi_arvalid && !s_axi_rvalid_r) begin
      s_axi_rvalid_r <= 1'b1;
      s_axi_rdata <= rdata;
    end else if (s_axi_rvalid_r && s_axi_rready) begin
      s_axi_rvalid_r <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid_r;
  assign s_axi_rvalid = s_axi_rvalid_r;
  assign s_axi_rresp = 2'h0;

  // Port state transitions.
  always_comb begin
    next_state = state;
    unique case (state)
      slpc_pkg::SLPC_DISABLED: begin
        if (cmd_enable && dis_cnt >= `SLPC_DIS_MIN_CHARS) next_state = slpc_pkg::SLPC_ENABLED;
      end
      slpc_pkg::SLPC_ENABLED: begin
        if (line_fault_i) next_state = slpc_pkg::SLPC_CHECK;
        else if (char_tick_i && rx_flag_i) next_state = slpc_pkg::SLPC_READY;
      end
      slpc_pkg::SLPC_READY: begin
        if (error_i || rx_link_reset_i) next_state = slpc_pkg::SLPC_CHECK;
      end
      slpc_pkg::SLPC_CHECK: begin
        if (cmd_enable) next_state = slpc_pkg::SLPC_READY;
      end
      default: next_state = slpc_pkg::SLPC_DISABLED;
    endcase
    if (cmd_disable || recovery_i || (rx_reset_frame_i && state != slpc_pkg::SLPC_READY)) begin
      next_state = slpc_pkg::SLPC_DISABLED;
    end
  end
  always_ff @(posedge clock_i) begin
    if (!resetn_i) state <= slpc_pkg::SLPC_DISABLED;
    else state <= next_state;
  end
  assign port_state_o = state;

  // Dwell counter in Disabled, in character periods, saturating.
  always_ff @(posedge clock_i) begin
    if (!resetn_i || state != slpc_pkg::SLPC_DISABLED) dis_cnt <= 16'h0000;
    else if (char_tick_i && dis_cnt != 16'hFFFF) dis_cnt <= dis_cnt + 16'h0001;
  end

  // Pacing and acknowledgement flags; entering Disabled re-initialises them.
  logic entering_dis;
  assign entering_dis = next_state == slpc_pkg::SLPC_DISABLED && state != slpc_pkg::SLPC_DISABLED;
  always_ff @(posedge clock_i) begin
    if (!resetn_i || entering_dis) begin
      tx_seq <= `SLPC_SEQ_INIT;
      rx_seq <= `SLPC_SEQ_INIT;
      wait_rr <= 1'b1;
      rr_pend <= 1'b1;
      wait_ack <= 1'b0;
      ack_pend <= 1'b0;
    end else begin
      if (char_tick_i && cur_frame_end_i && !cur_frame_abort_i) begin
        tx_seq <= tx_seq + 2'h1;
        wait_ack <= 1'b1;
        wait_rr <= 1'b1;
      end else if (rx_ack_pair_i) begin
        wait_ack <= 1'b0;
      end
      if (rx_rr_pair_i && state == slpc_pkg::SLPC_READY) wait_rr <= 1'b0;
      if (rx_accept_o && rx_len == 8'(`SLPC_RX_BYTES - 1)) rx_seq <= rx_seq + 2'h1;
    end
  end

  // Link reset flag and error latch; an error in the software clear cycle wins, Disabled clears both.
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      link_reset_flag <= 1'b0;
      err_latch <= 1'b0;
    end else if (state == slpc_pkg::SLPC_DISABLED || entering_dis) begin
      link_reset_flag <= 1'b0;
      err_latch <= 1'b0;
    end else begin
      if (rx_link_reset_i) link_reset_flag <= 1'b1;
      if (error_i) err_latch <= 1'b1;
      else if (wr_go && aw_addr == `SLPC_OFS_CTRL && w_data[`SLPC_CTRL_CLR_ERR]) err_latch <= 1'b0;
    end
  end

  // Buffer pointers survive Disabled; only reset or software clears them.
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      tx_ptr <= 3'h0;
      retry_ptr <= 3'h0;
    end else if (wr_go && aw_addr == `SLPC_OFS_CTRL && w_data[`SLPC_CTRL_RETRY_RESET]) begin
      tx_ptr <= 3'h0;
      retry_ptr <= 3'h0;
    end else begin
      if (char_tick_i && cur_frame_end_i && !cur_frame_abort_i) tx_ptr <= tx_ptr + 3'h1;
      if (rx_ack_pair_i && wait_ack && retry_ptr != tx_ptr) retry_ptr <= retry_ptr + 3'h1;
    end
  end
  assign unacked = {1'b0, tx_ptr - retry_ptr};
  assign tx_ptr_o = tx_ptr;
  assign retry_ptr_o = retry_ptr;

  // Receive byte count for one whole frame; reset frames are taken in every state.
  // one full frame buffer
  always_ff @(posedge clock_i) begin
    if (!resetn_i || rx_flag_i) rx_len <= 8'h00;
    else if (rx_accept_o && rx_len != 8'(`SLPC_RX_BYTES)) rx_len <= rx_len + 8'h01;
  end
  assign rx_accept_o = rx_sync_i && (state == slpc_pkg::SLPC_READY || rx_reset_frame_i);

  // Initial FLAG run after entering Ready.
  always_ff @(posedge clock_i) begin
    if (!resetn_i || state != slpc_pkg::SLPC_READY) flag_cnt <= 4'h0;
    else if (char_tick_i && flag_cnt != `SLPC_READY_FLAGS) flag_cnt <= flag_cnt + 4'h1;
  end

  // Transmit arbiter, highest priority first.
  // one character each period keeps full bandwidth
  // forwarded frames continue back to back
  always_comb begin
    next_char = slpc_pkg::SLPC_CH_DIS;
    if (state == slpc_pkg::SLPC_DISABLED) next_char = slpc_pkg::SLPC_CH_DIS;
    else if (state == slpc_pkg::SLPC_ENABLED) next_char = slpc_pkg::SLPC_CH_FLAG;
    else if (state == slpc_pkg::SLPC_READY && flag_cnt != `SLPC_READY_FLAGS) next_char = slpc_pkg::SLPC_CH_FLAG;
    else if (pair_half != 3'h0) next_char = slpc_pkg::slpc_char_type'({1'b0, pair_half});
    else if (sat_pending_i && state == slpc_pkg::SLPC_READY) next_char = slpc_pkg::SLPC_CH_SAT;
    else if (satp_pending_i && state == slpc_pkg::SLPC_READY) next_char = slpc_pkg::SLPC_CH_SATP;
    else if (user_pending_i || user_req) next_char = slpc_pkg::SLPC_CH_USER;
    else if (ack_req && state == slpc_pkg::SLPC_READY) next_char = slpc_pkg::SLPC_CH_ACK;
    else if (rr_req && state == slpc_pkg::SLPC_READY) next_char = slpc_pkg::SLPC_CH_RR;
    else if (cur_frame_i) next_char = slpc_pkg::SLPC_CH_CUR_FRAME;
    else if (fwd_reset_i) next_char = slpc_pkg::SLPC_CH_FWD_RESET;
    else if (ctrl_req) next_char = slpc_pkg::SLPC_CH_CTRL_FRAME;
    else if (state == slpc_pkg::SLPC_READY && !wait_rr && (own_req || fwd_frame_i)) begin
      if (own_req && (sat_token_i || !fwd_frame_i)) next_char = slpc_pkg::SLPC_CH_OWN_FRAME;
      else next_char = slpc_pkg::SLPC_CH_FWD_FRAME;
    end else next_char = slpc_pkg::SLPC_CH_FLAG;
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      tx_char <= 4'(slpc_pkg::SLPC_CH_DIS);
      pair_half <= 3'h0;
    end else if (char_tick_i) begin
      tx_char <= 4'(next_char);
      if (pair_half != 3'h0) pair_half <= 3'h0;
      else if (next_char == slpc_pkg::SLPC_CH_ACK) pair_half <= 3'(slpc_pkg::SLPC_CH_ACK);
      else if (next_char == slpc_pkg::SLPC_CH_RR) pair_half <= 3'(slpc_pkg::SLPC_CH_RR);
      else if (cur_frame_abort_i && next_char == slpc_pkg::SLPC_CH_CUR_FRAME) pair_half <= 3'(slpc_pkg::SLPC_CH_FLAG);
    end
  end
  assign tx_char_o = tx_char;

  // Checks on the state machine and arbiter.
  sequence s_enter_ready;
    state != slpc_pkg::SLPC_READY ##1 state == slpc_pkg::SLPC_READY;
  endsequence
  a_ready_flag_run: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state == slpc_pkg::SLPC_READY && flag_cnt != `SLPC_READY_FLAGS && char_tick_i)
      |=> tx_char == 4'(slpc_pkg::SLPC_CH_FLAG)) else $error("non-FLAG sent in initial run");
  a_ready_cnt_start: assert property (@(posedge clock_i) disable iff (!resetn_i)
    s_enter_ready |-> flag_cnt == 4'h0) else $error("FLAG run not restarted");
  a_disabled_dis: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state == slpc_pkg::SLPC_DISABLED && char_tick_i) |=> tx_char == 4'(slpc_pkg::SLPC_CH_DIS))
    else $error("Disabled port sent other than DIS");
  a_dwell_min: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state == slpc_pkg::SLPC_DISABLED && next_state == slpc_pkg::SLPC_ENABLED)
      |-> dis_cnt >= `SLPC_DIS_MIN_CHARS) else $error("left Disabled too early");
  a_dis_init: assert property (@(posedge clock_i) disable iff (!resetn_i)
    entering_dis |=> (wait_rr && rr_pend && !wait_ack && tx_seq == 2'h0)) else $error("Disabled entry init wrong");
  a_lrf_clear: assert property (@(posedge clock_i) disable iff (!resetn_i)
    state == slpc_pkg::SLPC_DISABLED |-> !link_reset_flag) else $error("link reset flag set in Disabled");
  a_txptr_step: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (char_tick_i && cur_frame_end_i && !cur_frame_abort_i && !(wr_go && aw_addr == `SLPC_OFS_CTRL))
      |=> tx_ptr == $past(tx_ptr) + 3'h1) else $error("transmit pointer did not advance");
  a_rr_block: assert property (@(posedge clock_i) disable iff (!resetn_i)
    wait_rr |-> (next_char != slpc_pkg::SLPC_CH_OWN_FRAME && next_char != slpc_pkg::SLPC_CH_FWD_FRAME))
    else $error("data frame chosen while waiting for RR");
  a_ready_to_check: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state == slpc_pkg::SLPC_READY && error_i && !cmd_disable && !recovery_i && !rx_reset_frame_i)
      |=> state == slpc_pkg::SLPC_CHECK) else $error("error did not enter Check");
endmodule

/* File: tb/slpc_remote_model.sv */
// Remote port model that answers the local port across the serial link.
`timescale 1ns/10ps
module slpc_remote_model (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic resetn_i,
  // Local transmitter and bench commands.
  input wire logic [3:0] tx_char_i,
  input wire logic link_up_i,
  input wire logic slow_i,
  input wire logic [1:0] pair_cmd_i,
  // Receiver events seen by the local port, bit 0 ACK pair and bit 1 RR pair.
  output logic rx_sync_o,
  output logic rx_flag_o,
  output logic [1:0] rx_pair_o
);
  logic [2:0] dly [2];
  // The remote side returns FLAG only once it is up, so the bench can hold the port in Enabled.
  // FLAG answers FLAG.
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      rx_sync_o <= 1'b0;
      rx_flag_o <= 1'b0;
    end else begin
      rx_sync_o <= 1'b1;
      rx_flag_o <= link_up_i && (tx_char_i == slpc_pkg::SLPC_CH_FLAG);
    end
  end
  // Each commanded pair arrives as one pulse after a short or a long turnaround.
  always_ff @(posedge clock_i) begin
    for (int k = 0; k < 2; k++) begin
      rx_pair_o[k] <= 1'b0;
      if (!resetn_i) begin
        dly[k] <= 3'h0;
      end else if (pair_cmd_i[k]) begin
        dly[k] <= slow_i ? 3'h6 : 3'h1;
      end else if (dly[k] != 3'h0) begin
        dly[k] <= dly[k] - 3'h1;
        rx_pair_o[k] <= (dly[k] == 3'h1);
      end
    end
  end
endmodule

/* File: tb/serial_link_port_control_bench.sv */
// Self-checking bench for the port state machine and transmit arbiter.
`timescale 1ns/10ps
`include "slpc_regs.svh"
module serial_link_port_control_bench;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, rx_sync, rx_flag, rx_accept;
  wire [1:0] bresp, rresp, rx_pair;
  wire [31:0] rdata;
  logic char_tick = 1'b0, error = 1'b0, recovery = 1'b0, sat = 1'b0, user = 1'b0;
  logic cur = 1'b0, cur_end = 1'b0, cur_abort = 1'b0, fwd_reset = 1'b0, fwd_frame = 1'b0;
  logic link_up = 1'b0, slow = 1'b0, sat_token = 1'b0;
  logic [1:0] cmd = 2'h0;
  logic [1:0] cnt = 2'h0;
  wire [3:0] tx_char, port_state;
  wire [2:0] tx_ptr, retry_ptr;
  int ticks = 0, cycles = 0, bad_count = 0, n_checks = 0;
  logic [31:0] d;
  logic [3:0] c;
  // Line fault, link reset, reset frames and SAT' are held quiet.
  slpc_port i_dut (.clock_i(clock_i), .resetn_i(resetn_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .char_tick_i(char_tick),
    .rx_sync_i(rx_sync), .rx_flag_i(rx_flag), .rx_ack_pair_i(rx_pair[0]), .rx_rr_pair_i(rx_pair[1]),
    .rx_link_reset_i(1'b0), .rx_reset_frame_i(1'b0), .error_i(error), .line_fault_i(1'b0),
    .recovery_i(recovery), .sat_pending_i(sat), .satp_pending_i(1'b0), .sat_token_i(sat_token),
    .user_pending_i(user), .cur_frame_i(cur), .cur_frame_end_i(cur_end), .cur_frame_abort_i(cur_abort),
    .fwd_reset_i(fwd_reset), .fwd_frame_i(fwd_frame), .tx_char_o(tx_char), .port_state_o(port_state),
    .tx_ptr_o(tx_ptr), .retry_ptr_o(retry_ptr), .rx_accept_o(rx_accept));
  slpc_remote_model i_remote (.clock_i(clock_i), .resetn_i(resetn_i), .tx_char_i(tx_char),
    .link_up_i(link_up), .slow_i(slow), .pair_cmd_i(cmd), .rx_sync_o(rx_sync), .rx_flag_o(rx_flag),
    .rx_pair_o(rx_pair));
  // Free-running clock.
  always #20 clock_i = ~clock_i;
  // Character period strobe every fourth cycle, tick count since reset and the hang limit.
  always @(posedge clock_i) begin
    cnt <= cnt + 2'h1;
    char_tick <= (cnt == 2'h3);
    ticks <= !resetn_i ? 0 : ticks + int'(char_tick);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      results();
    end
  end
  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_char(input string n, input logic [3:0] e, input logic [3:0] g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED %s expected char %h seen %h", n, e, g);
    end
  endtask
  // Both address and data are offered at once and each is released at the edge that takes it.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v);
    logic aw_hit, w_hit;
    @(posedge clock_i);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clock_i);
      aw_hit = awvalid && (awready === 1'b1);
      w_hit = wvalid && (wready === 1'b1);
      @(posedge clock_i);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
    end while ((awvalid && !aw_hit) || (wvalid && !w_hit));
    do @(negedge clock_i); while (bvalid !== 1'b1);
    chk_word("write response", 32'h0, {30'h0, bresp});
    @(posedge clock_i);
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clock_i); while (arready !== 1'b1);
    @(posedge clock_i);
    arvalid <= 1'b0;
    do @(negedge clock_i); while (rvalid !== 1'b1);
    v = rdata;
    chk_word("read response", 32'h0, {30'h0, rresp});
    @(posedge clock_i);
    rready <= 1'b0;
  endtask
  // The character chosen at the next tick, sampled once the register has taken it.
  task automatic next_char(output logic [3:0] ch);
    do @(negedge clock_i); while (char_tick !== 1'b1);
    @(posedge clock_i);
    @(negedge clock_i);
    ch = tx_char;
  endtask
  task automatic wait_state(input logic [3:0] e);
    for (int i = 0; i < 400 && port_state !== e; i++) @(negedge clock_i);
    chk_word("port state", {28'h0, e}, {28'h0, port_state});
  endtask
  // The trailing FLAG strobe must ride on a tick, so it waits for the edge that raises one.
  task automatic end_frame(input logic ab);
    do @(negedge clock_i); while (cnt !== 2'h3);
    @(posedge clock_i);
    cur_end <= 1'b1;
    cur_abort <= ab;
    cur <= 1'b0;
    @(posedge clock_i);
    cur_end <= 1'b0;
    repeat (3) @(negedge clock_i);
  endtask
  // The turnaround of the remote model is at most seven cycles, so ten always cover it.
  task automatic remote_pair(input int k, input logic sl);
    @(posedge clock_i);
    slow <= sl;
    cmd <= 2'h1 << k;
    @(posedge clock_i);
    cmd <= 2'h0;
    repeat (10) @(negedge clock_i);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence: bring the link up, walk the priorities, then fault and recover.
  initial begin
    repeat (12) @(posedge clock_i);
    resetn_i <= 1'b1;
    sat <= 1'b1;
    user <= 1'b1;
    fwd_reset <= 1'b1;
    @(negedge clock_i);
    chk_word("state after reset", 32'h1, {28'h0, port_state});
    next_char(c);
    chk_char("disabled char", slpc_pkg::SLPC_CH_DIS, c);
    axi_write(`SLPC_OFS_CTRL, 32'h1);
    axi_write(`SLPC_OFS_REQ, 32'h3);
    while (ticks < 150) @(negedge clock_i);
    chk_word("early enable", 32'h1, {28'h0, port_state});
    while (ticks < 205) @(negedge clock_i);
    axi_write(`SLPC_OFS_CTRL, 32'h1);
    wait_state(slpc_pkg::SLPC_ENABLED);
    next_char(c);
    chk_char("enabled char", slpc_pkg::SLPC_CH_FLAG, c);
    @(posedge clock_i);
    link_up <= 1'b1;
    cur <= 1'b1;
    wait_state(slpc_pkg::SLPC_READY);
    chk_word("rx accept ready", 32'h1, {31'h0, rx_accept});
    for (int i = 0; i < 10; i++) begin
      next_char(c);
      chk_char("lead flag", slpc_pkg::SLPC_CH_FLAG, c);
    end
    next_char(c);
    chk_char("sat", slpc_pkg::SLPC_CH_SAT, c);
    @(posedge clock_i) sat <= 1'b0;
    next_char(c);
    chk_char("user", slpc_pkg::SLPC_CH_USER, c);
    @(posedge clock_i) user <= 1'b0;
    next_char(c);
    chk_char("ack first", slpc_pkg::SLPC_CH_ACK, c);
    next_char(c);
    chk_char("ack second", slpc_pkg::SLPC_CH_ACK, c);
    next_char(c);
    chk_char("rr first", slpc_pkg::SLPC_CH_RR, c);
    next_char(c);
    chk_char("rr second", slpc_pkg::SLPC_CH_RR, c);
    next_char(c);
    chk_char("current frame", slpc_pkg::SLPC_CH_CUR_FRAME, c);
    end_frame(1'b0);
    chk_word("tx ptr clean end", 32'h1, {29'h0, tx_ptr});
    next_char(c);
    chk_char("forward reset", slpc_pkg::SLPC_CH_FWD_RESET, c);
    @(posedge clock_i);
    fwd_reset <= 1'b0;
    fwd_frame <= 1'b1;
    next_char(c);
    chk_char("paced idle", slpc_pkg::SLPC_CH_FLAG, c);
    axi_read(`SLPC_OFS_STATUS, d);
    chk_word("status state", 32'h4, d & 32'hF);
    remote_pair(0, 1'b1);
    chk_word("retry after ack", 32'h1, {29'h0, retry_ptr});
    remote_pair(0, 1'b0);
    chk_word("retry spare ack", 32'h1, {29'h0, retry_ptr});
    remote_pair(1, 1'b0);
    next_char(c);
    chk_char("forwarded frame", slpc_pkg::SLPC_CH_FWD_FRAME, c);
    axi_write(`SLPC_OFS_REQ, 32'h8);
    next_char(c);
    chk_char("forward over own", slpc_pkg::SLPC_CH_FWD_FRAME, c);
    @(posedge clock_i) sat_token <= 1'b1;
    next_char(c);
    chk_char("own with token", slpc_pkg::SLPC_CH_OWN_FRAME, c);
    @(posedge clock_i) sat_token <= 1'b0;
    @(posedge clock_i) cur <= 1'b1;
    next_char(c);
    chk_char("frame over forward", slpc_pkg::SLPC_CH_CUR_FRAME, c);
    end_frame(1'b1);
    chk_word("tx ptr abort", 32'h1, {29'h0, tx_ptr});
    @(posedge clock_i);
    cur_abort <= 1'b0;
    error <= 1'b1;
    @(posedge clock_i) error <= 1'b0;
    wait_state(slpc_pkg::SLPC_CHECK);
    next_char(c);
    next_char(c);
    chk_char("check char", slpc_pkg::SLPC_CH_FLAG, c);
    chk_word("rx accept check", 32'h0, {31'h0, rx_accept});
    @(posedge clock_i) recovery <= 1'b1;
    @(posedge clock_i) recovery <= 1'b0;
    wait_state(slpc_pkg::SLPC_DISABLED);
    next_char(c);
    chk_char("recovery char", slpc_pkg::SLPC_CH_DIS, c);
    chk_word("rx accept disabled", 32'h0, {31'h0, rx_accept});
    axi_read(`SLPC_OFS_STATUS, d);
    chk_word("status after disable", 32'h1, d);
    axi_read(`SLPC_OFS_FLAGS, d);
    chk_word("flags after disable", 32'hC, d);
    axi_read(`SLPC_OFS_PTRS, d);
    chk_word("kept pointers", 32'h11, d & 32'h77);
    axi_read(8'h1C, d);
    chk_word("unmapped read", 32'h0, d);
    results();
  end
endmodule
